// file: core_pkg.sv
// Shared constants, encodings and carrier types for the instruction core.
package core_pkg;

  // Widths of the data path, file address, program counter and instruction word.
  localparam int DATA_W  = 8;
  localparam int FILE_AW = 5;
  localparam int PC_W    = 11;
  localparam int INSTR_W = 12;

  // The flag byte is seen by file instructions at this location.
  localparam logic [4:0] STATUS_ADDR = 5'h03;

  // Flag byte layout.
  localparam int C_BIT       = 0;
  localparam int DC_BIT      = 1;
  localparam int Z_BIT       = 2;
  localparam int PD_BIT      = 3;
  localparam int TO_BIT      = 4;
  localparam int PAGE_LO_BIT = 5;
  localparam int PAGE_HI_BIT = 6;

  // Reset values of core state.
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  ACCUM_RST  = 8'h00;
  localparam logic [10:0] PC_RST     = 11'h000;
  localparam logic [1:0]  CTRL_RST   = 2'h0;

  // Instruction word fields.
  localparam int DEST_BIT = 5;
  localparam int SKIP_BIT = 6;

  // Opcode nibble in bits 11:8; the jump uses prefix bits 11:9.
  localparam logic [2:0] JUMP_PREFIX = 3'h7;
  localparam logic [3:0] OPC_MISC    = 4'h0;
  localparam logic [3:0] OPC_ADD     = 4'h1;
  localparam logic [3:0] OPC_AND     = 4'h2;
  localparam logic [3:0] OPC_COM     = 4'h3;
  localparam logic [3:0] OPC_DEC     = 4'h4;
  localparam logic [3:0] OPC_INC     = 4'h5;
  localparam logic [3:0] OPC_ANDL    = 4'h6;
  localparam logic [3:0] OPC_ORL     = 4'h7;
  localparam logic [3:0] OPC_CALL    = 4'h8;
  localparam logic [3:0] OPC_BCLR    = 4'h9;
  localparam logic [3:0] OPC_BSET    = 4'ha;
  localparam logic [3:0] OPC_TSTL    = 4'hb;
  localparam logic [3:0] OPC_TSTH    = 4'hc;

  // Sub codes of the miscellaneous group.
  localparam logic [2:0] MISC_ZACC  = 3'h2;
  localparam logic [2:0] MISC_ZFILE = 3'h3;
  localparam logic [7:0] KICK_CODE  = 8'h04;

  // Wishbone register byte offsets and control bits.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_FLAGS  = 8'h04;
  localparam logic [7:0] REG_ACCUM  = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0c;
  localparam logic [7:0] REG_WDOG   = 8'h10;
  localparam logic [7:0] REG_TOS    = 8'h14;
  localparam int         CTRL_RUN_BIT = 0;
  localparam int         CTRL_PSA_BIT = 1;

  // Watchdog counter and prescaler widths.
  localparam int WDOG_W  = 8;
  localparam int PRESC_W = 8;

  typedef enum logic [4:0] {
    nop_op, add_accum_to_file, and_accum_with_file, invert_file_op,
    minus_one_op, minus_one_skip_nil_op, plus_one_op,
    plus_one_skip_nil_op, and_literal_into_accum, or_literal_into_accum,
    call_op, bit_clear_op, bit_set_op, test_skip_if_low,
    test_skip_if_high, zero_accum_op, zero_file_op, watchdog_kick_op,
    jump_op
  } op_type;

  typedef enum logic [1:0] {
    st_fetch, st_exec, st_nop_fetch, st_nop_exec
  } core_state_type;

  typedef struct packed {
    op_type     op;
    logic       dest_file;
    logic [4:0] faddr;
    logic [2:0] bsel;
    logic [8:0] lit;
  } decoded_type;

  typedef struct packed {
    logic       en;
    logic [4:0] addr;
    logic [7:0] data;
  } file_wr_type;

endpackage

// file: file_ram.sv
// General purpose file register memory with a registered read port.
`timescale 1ns/1ps
module file_ram
  import core_pkg::*;
#(
  parameter int DEPTH = 32
)
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire core_pkg::file_wr_type wr_i,
  input  wire logic [4:0]          raddr_i,
  output logic      [7:0]          rdata_o
);

  logic [7:0] mem [DEPTH];

  // Writes land at the edge; a read of the same address sees old data.
  always_ff @(posedge clk_i)
  begin
    if (wr_i.en)
    begin
      mem[wr_i.addr] <= wr_i.data;
    end
  end

  // Read data comes from a register, so callers see it one edge later.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 8'h00;
    end
    else
    begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule // file_ram

// file: watchdog.sv
// Watchdog counter with a shared prescaler that software may assign.
`timescale 1ns/1ps
module watchdog
  import core_pkg::*;
#(
  parameter int CNT_W = WDOG_W,
  parameter int PRE_W = PRESC_W
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             kick_i,
  input  wire logic             psa_i,
  output logic      [CNT_W-1:0] count_o,
  output logic                  expire_o
);

  logic [PRE_W-1:0] presc;
  logic             tick;

  // With the prescaler on the watchdog it divides; else every clock ticks.
  assign tick = psa_i ? (presc == '1) : 1'b1;

  // The prescaler is only cleared by a kick while it belongs to us.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (kick_i && psa_i))
    begin
      presc <= '0;
    end
    else
    begin
      presc <= presc + 1'b1;
    end
  end

  // Counter and its overflow pulse; a kick beats a pending overflow.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || kick_i)
    begin
      count_o  <= '0;
      expire_o <= 1'b0;
    end
    else
    begin
      expire_o <= tick && (count_o == '1);
      if (tick)
      begin
        count_o <= count_o + 1'b1;
      end
    end
  end

endmodule // watchdog

// file: core_instruction_semantics.sv
// Instruction execution core with a Wishbone control and status slave.
//
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module core_instruction_semantics #(
  parameter int STACK_DEPTH = 2
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  output logic      [10:0] pc_o,
  input  wire logic [11:0] instr_i,
  output logic             wdog_expire_o
);
  import core_pkg::*;

  core_state_type   state;
  logic [11:0]      ir;
  decoded_type      ir_d;
  decoded_type      fetch_d;
  logic [7:0]       accum;
  logic [7:0]       status;
  logic [1:0]       ctrl;
  logic [10:0]      stack [STACK_DEPTH];
  logic [7:0]       ram_rdata;
  logic [7:0]       fval;
  logic [4:0]       raddr;
  file_wr_type      ram_wr;
  logic [7:0]       wdog_count;
  logic             wdog_expire;
  logic             exec;
  logic [8:0]       sum9;
  logic [4:0]       sum5;
  logic [7:0]       result;
  logic [7:0]       next_accum;
  logic [7:0]       next_status;
  logic [10:0]      next_pc;
  logic [10:0]      pc_q;
  logic             wr_file;
  logic             upd_z;
  logic             upd_c;
  logic             skip;
  logic             branch;
  logic             push;
  logic             kick;
  logic             wb_req;

  // Splits a word into operation and operand fields; bad codes become nops.
  function automatic decoded_type decode(input logic [11:0] ins);
    decoded_type d;
    d.op        = nop_op;
    d.dest_file = ins[DEST_BIT];
    d.faddr     = ins[4:0];
    d.bsel      = ins[7:5];
    d.lit       = ins[8:0];
    if (ins[11:9] == JUMP_PREFIX)
    begin
      d.op = jump_op;
    end
    else
    begin
      case (ins[11:8])
        OPC_MISC:
        begin
          if (ins[7:5] == MISC_ZACC)
          begin
            d.op = zero_accum_op;
          end
          else if (ins[7:5] == MISC_ZFILE)
          begin
            d.op = zero_file_op;
          end
          else if (ins[7:0] == KICK_CODE)
          begin
            d.op = watchdog_kick_op;
          end
        end
        OPC_ADD:  d.op = add_accum_to_file;
        OPC_AND:  d.op = and_accum_with_file;
        OPC_COM:  d.op = invert_file_op;
        OPC_DEC:  d.op = ins[SKIP_BIT] ? minus_one_skip_nil_op : minus_one_op;
        OPC_INC:  d.op = ins[SKIP_BIT] ? plus_one_skip_nil_op : plus_one_op;
        OPC_ANDL: d.op = and_literal_into_accum;
        OPC_ORL:  d.op = or_literal_into_accum;
        OPC_CALL: d.op = call_op;
        OPC_BCLR: d.op = bit_clear_op;
        OPC_BSET: d.op = bit_set_op;
        OPC_TSTL: d.op = test_skip_if_low;
        OPC_TSTH: d.op = test_skip_if_high;
        default:  d.op = nop_op;
      endcase
    end
    return d;
  endfunction

  // The same decoder serves the fetch address and the execute stage.
  assign fetch_d = decode(instr_i);
  assign ir_d    = decode(ir);
  assign exec    = (state == st_exec);
  assign pc_o    = pc_q;

  // The file operand is read during fetch so it is ready in execute.
  assign raddr = (state == st_fetch) ? fetch_d.faddr : ir_d.faddr;
  assign fval  = (ir_d.faddr == STATUS_ADDR) ? status : ram_rdata;

  file_ram #(
    .DEPTH   (32)
  ) u_file_ram (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (ram_wr),
    .raddr_i (raddr),
    .rdata_o (ram_rdata)
  );

  watchdog u_watchdog (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .kick_i   (exec && kick),
    .psa_i    (ctrl[CTRL_PSA_BIT]),
    .count_o  (wdog_count),
    .expire_o (wdog_expire)
  );

  // Carry out of bit 7 and of bit 3 come from these widened sums.
  assign sum9 = {1'b0, accum} + {1'b0, fval};
  assign sum5 = {1'b0, accum[3:0]} + {1'b0, fval[3:0]};

  // Execute stage: result, destination, flags and program flow.
  always_comb
  begin
    result     = fval;
    next_accum = accum;
    wr_file    = 1'b0;
    upd_z      = 1'b0;
    upd_c      = 1'b0;
    skip       = 1'b0;
    branch     = 1'b0;
    push       = 1'b0;
    kick       = 1'b0;
    next_pc    = pc_q + 11'h001;
    case (ir_d.op)
      add_accum_to_file:
      begin
        result = sum9[7:0];
        upd_z  = 1'b1;
        upd_c  = 1'b1;
      end
      and_accum_with_file:
      begin
        result = accum & fval;
        upd_z  = 1'b1;
      end
      invert_file_op:
      begin
        result = ~fval;
        upd_z  = 1'b1;
      end
      minus_one_op:
      begin
        result = fval - 8'h01;
        upd_z  = 1'b1;
      end
      minus_one_skip_nil_op:
      begin
        result = fval - 8'h01;
        skip   = (result == 8'h00);
      end
      plus_one_op:
      begin
        result = fval + 8'h01;
        upd_z  = 1'b1;
      end
      plus_one_skip_nil_op:
      begin
        result = fval + 8'h01;
        skip   = (result == 8'h00);
      end
      and_literal_into_accum:
      begin
        result = accum & ir_d.lit[7:0];
        upd_z  = 1'b1;
      end
      or_literal_into_accum:
      begin
        result = accum | ir_d.lit[7:0];
        upd_z  = 1'b1;
      end
      zero_accum_op:
      begin
        result = 8'h00;
        upd_z  = 1'b1;
      end
      zero_file_op:
      begin
        result = 8'h00;
        upd_z  = 1'b1;
      end
      bit_clear_op:
      begin
        result = fval & ~(8'h01 << ir_d.bsel);
      end
      bit_set_op:
      begin
        result = fval | (8'h01 << ir_d.bsel);
      end
      test_skip_if_low:
      begin
        skip = ~fval[ir_d.bsel];
      end
      test_skip_if_high:
      begin
        skip = fval[ir_d.bsel];
      end
      call_op:
      begin
        branch  = 1'b1;
        push    = 1'b1;
        next_pc = {status[PAGE_HI_BIT:PAGE_LO_BIT], 1'b0,
                   ir_d.lit[7:0]};
      end
      jump_op:
      begin
        branch  = 1'b1;
        next_pc = {status[PAGE_HI_BIT:PAGE_LO_BIT], ir_d.lit};
      end
      watchdog_kick_op:
      begin
        kick = 1'b1;
      end
      default:
      begin
        result = fval;
      end
    endcase
    // Routing of the result: by the destination bit for the file ops, fixed for the others.
    case (ir_d.op)
      add_accum_to_file, and_accum_with_file, invert_file_op,
      minus_one_op, minus_one_skip_nil_op, plus_one_op,
      plus_one_skip_nil_op:
      begin
        if (ir_d.dest_file)
        begin
          wr_file = 1'b1;
        end
        else
        begin
          next_accum = result;
        end
      end
      and_literal_into_accum, or_literal_into_accum, zero_accum_op:
      begin
        next_accum = result;
      end
      zero_file_op, bit_clear_op, bit_set_op:
      begin
        wr_file = 1'b1;
      end
      default:
      begin
        wr_file = 1'b0;
      end
    endcase
  end

  // Flags are applied after a direct write to the flag byte, so they win.
  always_comb
  begin
    next_status = status;
    if (wr_file && (ir_d.faddr == STATUS_ADDR))
    begin
      next_status = result;
    end
    if (upd_z)
    begin
      next_status[Z_BIT] = (result == 8'h00);
    end
    if (upd_c)
    begin
      next_status[C_BIT]  = sum9[8];
      next_status[DC_BIT] = sum5[4];
    end
    if (wdog_expire)
    begin
      next_status[TO_BIT] = 1'b0;
    end
    if (kick)
    begin
      next_status[TO_BIT] = 1'b1;
      next_status[PD_BIT] = 1'b1;
    end
  end

  // The flag byte itself is not in the memory, so its writes skip it.
  assign ram_wr = {exec && wr_file && (ir_d.faddr != STATUS_ADDR),
                   ir_d.faddr, result};

  // Sequencer: a taken skip or branch spends one nop instruction cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= st_fetch;
      ir    <= 12'h000;
    end
    else
    begin
      case (state)
        st_fetch:
        begin
          if (ctrl[CTRL_RUN_BIT])
          begin
            ir    <= instr_i;
            state <= st_exec;
          end
        end
        st_exec:      state <= (skip || branch) ? st_nop_fetch : st_fetch;
        st_nop_fetch: state <= st_nop_exec;
        st_nop_exec:  state <= st_fetch;
        default:      state <= st_fetch;
      endcase
    end
  end

  // Program counter; a skip steps over the discarded word.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_q <= PC_RST;
    end
    else if (exec)
    begin
      pc_q <= skip ? (pc_q + 11'h002) : next_pc;
    end
  end

  // Return stack; the oldest entry falls off when it overflows.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stack[i] <= PC_RST;
      end
    end
    else if (exec && push)
    begin
      stack[0] <= pc_q + 11'h001;
      for (int i = 1; i < STACK_DEPTH; i++)
      begin
        stack[i] <= stack[i-1];
      end
    end
  end

  // Accumulator and flag byte.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      accum  <= ACCUM_RST;
      status <= STATUS_RST;
    end
    else if (exec)
    begin
      accum  <= next_accum;
      status <= next_status;
    end
    else if (wdog_expire)
    begin
      status[TO_BIT] <= 1'b0;
    end
  end

  assign wdog_expire_o = wdog_expire;

  // Wishbone slave: one wait state, ack drops the cycle after it rose.
  assign wb_req = cyc_i && stb_i && !ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      ctrl  <= CTRL_RST;
    end
    else
    begin
      ack_o <= wb_req;
      if (wb_req && we_i && sel_i[0] && (adr_i == REG_CTRL))
      begin
        ctrl <= dat_i[1:0];
      end
      if (wb_req && !we_i)
      begin
        case (adr_i)
          REG_CTRL:  dat_o <= {30'h0000_0000, ctrl};
          REG_FLAGS: dat_o <= {24'h00_0000, status};
          REG_ACCUM: dat_o <= {24'h00_0000, accum};
          REG_PC:    dat_o <= {21'h00_0000, pc_q};
          REG_WDOG:  dat_o <= {24'h00_0000, wdog_count};
          REG_TOS:   dat_o <= {21'h00_0000, stack[0]};
          default:   dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  property p_zero_accum;
    @(posedge clk_i) disable iff (rst_i)
    exec && (ir_d.op == zero_accum_op) |=> (accum == 8'h00) && status[Z_BIT];
  endproperty
  a_zero_accum: assert property (p_zero_accum)
    else $error("zero accum did not clear or set nil flag");

  property p_add;
    @(posedge clk_i) disable iff (rst_i)
    exec && (ir_d.op == add_accum_to_file) && !ir_d.dest_file
      |=> accum == ($past(accum) + $past(fval));
  endproperty
  a_add: assert property (p_add)
    else $error("add result wrong");

  property p_skip_cycles;
    @(posedge clk_i) disable iff (rst_i)
    exec && skip |=> (state == st_nop_fetch) ##1 (state == st_nop_exec)
      ##1 (state == st_fetch);
  endproperty
  a_skip_cycles: assert property (p_skip_cycles)
    else $error("skip did not insert one nop cycle");

  property p_bit_noflags;
    @(posedge clk_i) disable iff (rst_i)
    exec && ((ir_d.op == bit_set_op) || (ir_d.op == bit_clear_op))
      && (ir_d.faddr != STATUS_ADDR) && !wdog_expire
      |=> $stable(status);
  endproperty
  a_bit_noflags: assert property (p_bit_noflags)
    else $error("bit op changed flags");

  property p_call;
    @(posedge clk_i) disable iff (rst_i)
    exec && (ir_d.op == call_op) |=> (pc_q[8] == 1'b0)
      && (pc_q[7:0] == $past(ir[7:0]))
      && (stack[0] == $past(pc_q) + 11'h001);
  endproperty
  a_call: assert property (p_call)
    else $error("call target or return address wrong");

  property p_jump;
    @(posedge clk_i) disable iff (rst_i)
    exec && (ir_d.op == jump_op) |=> (pc_q[8:0] == $past(ir[8:0]))
      && (pc_q[10:9] == $past(status[PAGE_HI_BIT:PAGE_LO_BIT]));
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");

  property p_kick;
    @(posedge clk_i) disable iff (rst_i)
    exec && kick |=> status[TO_BIT] && status[PD_BIT]
      && (wdog_count == 8'h00);
  endproperty
  a_kick: assert property (p_kick)
    else $error("kick did not clear watchdog or set flags");

  property p_nil_flag;
    @(posedge clk_i) disable iff (rst_i)
    exec && upd_z |=> status[Z_BIT] == ($past(result) == 8'h00);
  endproperty
  a_nil_flag: assert property (p_nil_flag)
    else $error("nil flag does not match result");

  property p_or_literal;
    @(posedge clk_i) disable iff (rst_i)
    exec && (ir_d.op == or_literal_into_accum)
      |=> accum == ($past(accum) | $past(ir[7:0]));
  endproperty
  a_or_literal: assert property (p_or_literal)
    else $error("or literal result wrong");

endmodule // core_instruction_semantics

// file: prog_mem.sv
// Program memory model that feeds the core one word per fetch.
`timescale 1ns/1ps
module prog_mem
(
  input  wire logic [10:0] pc_i,
  output logic      [11:0] instr_o
);
  logic [11:0] words [0:2047];

  // Unwritten words read as no-operation, so a stray fetch is harmless.
  initial
  begin
    for (int i = 0; i < 2048; i++)
      words[i] = 12'h000;
  end

  // The fetch is combinational because the core samples in the same cycle.
  assign instr_o = words[pc_i];
endmodule // prog_mem

// file: core_instruction_semantics_tb.sv
// Self-checking bench for the instruction core and its register slave.
`timescale 1ns/1ps
module core_instruction_semantics_tb;
  import core_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        we;
  logic [3:0]  sel;
  logic        cyc;
  logic        stb;
  logic        ack;
  logic [10:0] pc;
  logic [11:0] instr;
  logic [31:0] q;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [2:0]  bs;
  logic [10:0] e;
  logic        wexp;
  int          n_exp;
  int          op;
  int          seed;
  int          error_cnt;
  int          compares;

  core_instruction_semantics DUT
  (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .adr_i         (adr),
    .dat_i         (wdat),
    .dat_o         (rdat),
    .we_i          (we),
    .sel_i         (sel),
    .cyc_i         (cyc),
    .stb_i         (stb),
    .ack_o         (ack),
    .pc_o          (pc),
    .instr_i       (instr),
    .wdog_expire_o (wexp)
  );

  prog_mem pmem
  (
    .pc_i    (pc),
    .instr_o (instr)
  );

  // Core clock at 20 MHz.
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Counts one comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Classic single cycle; the request is held until ack is sampled high.
  task automatic wb(input logic [7:0] ad, input logic w,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    adr  <= ad;
    wdat <= d;
    we   <= w;
    sel  <= 4'hf;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    @(posedge clk_i);
    n = 0;
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50)
      check(32'h0, 32'h1, "no ack");
  endtask

  // Reads one register and compares it.
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp,
                        input string what);
    wb(ad, 1'b0, 32'h0);
    check(q, exp, what);
  endtask

  // Holds reset for five edges; it also clears the program counter.
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Lets the core run for a while, then halts it in fetch.
  task automatic run(input int n);
    wb(REG_CTRL, 1'b1, 32'h1);
    repeat (n) @(posedge clk_i);
    wb(REG_CTRL, 1'b1, 32'h0);
  endtask

  // Word under test: file 8 holds x, the accumulator holds the other.
  function automatic logic [11:0] enc_of(int o, logic [7:0] x,
                                         logic [2:0] k);
    case (o)
      0: return {OPC_ADD, 8'h08};
      1: return {OPC_AND, 8'h08};
      2: return {OPC_COM, 8'h08};
      3: return {OPC_DEC, 8'h08};
      4: return {OPC_INC, 8'h08};
      5: return {OPC_ANDL, x};
      6: return {OPC_ORL, x};
      7: return {OPC_DEC, 8'h48};
      8: return {OPC_INC, 8'h48};
      9: return {OPC_BCLR, k, 5'h08};
      10: return {OPC_BSET, k, 5'h08};
      11: return {OPC_TSTL, k, 5'h08};
      default: return {OPC_TSTH, k, 5'h08};
    endcase
  endfunction

  // Follow-up word: skips show as an untouched nil flag, bit ops as a read.
  function automatic logic [11:0] next_of(int o);
    if (o == 7 || o == 8 || o == 11 || o == 12)
      return {OPC_MISC, MISC_ZFILE, 5'h09};
    if (o == 9 || o == 10)
      return {OPC_AND, 8'h08};
    return 12'h000;
  endfunction

  // Expected accumulator and low flags; carries were clear before the op.
  function automatic logic [10:0] expect_of(int o, logic [7:0] x,
                                            logic [7:0] y, logic [2:0] k);
    logic [8:0] r;
    logic       sk;
    logic       dc;
    logic       zo;
    case (o)
      0: r = x + y;
      1: r = {1'b0, x & y};
      2: r = {1'b0, ~x};
      3: r = {1'b0, x - 8'h01};
      4: r = {1'b0, x + 8'h01};
      5: r = {1'b0, x & y};
      6: r = {1'b0, x | y};
      7: r = {1'b0, x - 8'h01};
      8: r = {1'b0, x + 8'h01};
      9: r = {1'b0, y & (x & ~(8'h01 << k))};
      10: r = {1'b0, y & (x | (8'h01 << k))};
      default: r = {1'b0, y};
    endcase
    sk = (o == 7 || o == 8) ? (r[7:0] == 8'h00) :
         (o == 11) ? !x[k] : (o == 12) ? x[k] : 1'b0;
    dc = (o == 0) && (({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0f);
    zo = (o == 7 || o == 8 || o > 10) ? (sk ? (y == 8'h00) : 1'b1)
                                      : (r[7:0] == 8'h00);
    return {r[7:0], zo, dc, (o == 0) & r[8]};
  endfunction

  // Main sequence.
  initial
  begin
    seed = 68787;
    error_cnt = 0;
    compares = 0;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    do_reset;
    wb(REG_ACCUM, 1'b1, 32'h0000_0055);
    wb(8'h40, 1'b1, 32'h0000_00ff);
    rd_chk(REG_CTRL, 32'h0, "ctrl");
    rd_chk(REG_FLAGS, 32'h0000_0018, "flags");
    rd_chk(REG_ACCUM, 32'h0, "accum");
    rd_chk(REG_PC, 32'h0, "pc");
    rd_chk(8'h40, 32'h0, "unmapped");
    // Each of the 13 ops of enc_of once with corner operands, then random ones.
    for (int i = 0; i < 43; i++)
    begin
      op = (i < 13) ? i : $unsigned($random(seed)) % 13;
      a = $random(seed);
      b = $random(seed);
      bs = $random(seed);
      if (i < 13)
      begin
        a = (op == 3 || op == 7) ? 8'h01 :
            (op == 4 || op == 8) ? 8'hff : 8'h80;
        b = 8'h80;
      end
      pmem.words[0] = {OPC_MISC, MISC_ZACC, 5'h00};
      pmem.words[1] = {OPC_ORL, a};
      pmem.words[2] = {OPC_MISC, MISC_ZFILE, 5'h08};
      pmem.words[3] = {OPC_ADD, 8'h28};
      pmem.words[4] = {OPC_MISC, MISC_ZACC, 5'h00};
      pmem.words[5] = {OPC_ORL, b};
      pmem.words[6] = enc_of(op, a, bs);
      pmem.words[7] = next_of(op);
      pmem.words[8] = {JUMP_PREFIX, 9'h008};
      e = expect_of(op, a, b, bs);
      do_reset;
      run(60);
      wb(REG_ACCUM, 1'b0, 32'h0);
      check(q, {24'h0, e[10:3]}, "accum");
      wb(REG_FLAGS, 1'b0, 32'h0);
      check({29'h0, q[2:0]}, {29'h0, e[2:0]}, "flags");
      rd_chk(REG_PC, 32'h0000_0008, "pc");
    end
    // Paged call and jump.
    pmem.words[0] = {OPC_BSET, 3'h6, 5'h03};
    pmem.words[1] = {OPC_CALL, 8'h40};
    pmem.words[11'h440] = {JUMP_PREFIX, 9'h140};
    pmem.words[11'h540] = {JUMP_PREFIX, 9'h140};
    do_reset;
    run(40);
    rd_chk(REG_PC, 32'h0000_0540, "jump");
    rd_chk(REG_TOS, 32'h0000_0002, "stack");
    // Kick after an overflow has cleared the timeout flag.
    pmem.words[0] = {OPC_MISC, KICK_CODE};
    pmem.words[1] = {JUMP_PREFIX, 9'h001};
    do_reset;
    // An unprescaled 8-bit count overflows once in 300 cycles.
    n_exp = 0;
    repeat (300)
    begin
      @(posedge clk_i);
      n_exp += (wexp === 1'b1);
    end
    check(n_exp, 32'h1, "expire pulses");
    wb(REG_FLAGS, 1'b0, 32'h0);
    check({31'h0, q[TO_BIT]}, 32'h0, "overflow");
    wb(REG_CTRL, 1'b1, 32'h3);
    repeat (10) @(posedge clk_i);
    rd_chk(REG_CTRL, 32'h3, "ctrl");
    wb(REG_CTRL, 1'b1, 32'h0);
    wb(REG_FLAGS, 1'b0, 32'h0);
    check({30'h0, q[4:3]}, 32'h3, "kick flags");
    wb(REG_WDOG, 1'b0, 32'h0);
    check({31'h0, q < 32'h28}, 32'h1, "kick count");
    report_and_stop;
  end

  // Cuts a hang short well after the expected run length.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("ERROR %0t timeout", $time);
    report_and_stop;
  end
endmodule // core_instruction_semantics_tb
